// File: spsahc_i2c_mst.sv
// Purpose: I2C bus master that drives the slave port's wires
// Assumes: Open-drain wires with pull-ups, pins sampled on pclk
// Notes:   A stretched SCL is waited on for at most 400 cycles
module spsahc_i2c_mst (
    input  wire logic pclk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low,
    output logic      timed_out
);
    localparam int H = 20;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
        timed_out = 1'b0;
    end

    task automatic hc();
        repeat (H) @(posedge pclk);
    endtask

    // Release SCL and wait while the slave stretches it
    task automatic up();
        int n;
        scl_low <= 1'b0;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (!scl && n < 400);
        if (!scl) timed_out <= 1'b1;
        hc();
    endtask

    // Start or repeated Start: SDA falls while SCL is high
    task automatic start();
        sda_low <= 1'b0;
        hc();
        up();
        sda_low <= 1'b1;
        hc();
        scl_low <= 1'b1;
        hc();
    endtask

    // Stop: SDA rises while SCL is high
    task automatic stop();
        sda_low <= 1'b1;
        hc();
        up();
        sda_low <= 1'b0;
        hc();
    endtask

    task automatic clk_bit(input logic b, output logic s);
        sda_low <= ~b;
        hc();
        up();
        s = sda;
        scl_low <= 1'b1;
        hc();
    endtask

    // Eight bits MSB first, then SDA released for the acknowledge
    task automatic send(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = ~s;
    endtask
endmodule // spsahc_i2c_mst

// File: ssp_baud_div.sv
// Purpose: Half-period tick for the master serial clock
// Assumes: div stable while en is high
// Notes:   Tick every 2*(div+1) cycles, so a full period is 4*(div+1)
module ssp_baud_div #(
    parameter int W = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         en,
    input  wire logic [W-1:0] div,
    output logic              tick
);
    logic [W:0] cnt;
    logic [W:0] last;

    assign last = {div, 1'b1};
    assign tick = en & (cnt == last);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0;
        end else if (!en || tick) begin
            cnt <= '0;
        end else begin
            cnt <= cnt + 1'b1;
        end
    end
endmodule // ssp_baud_div

// File: ssp_edge.sv
// Purpose: Rising and falling edge detect on a group of pins
// Assumes: Inputs synchronous to pclk
// Notes:   Edges are combinational, one cycle wide
module ssp_edge #(
    parameter int W = 3
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] rise,
    output logic      [W-1:0] fall
);
    logic [W-1:0] prev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prev <= '1;
        end else begin
            prev <= d;
        end
    end

    assign rise = d & ~prev;
    assign fall = ~d & prev;
endmodule // ssp_edge

// File: ssp_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: 40 MHz pclk, APB byte addresses, one aligned word per register
// Notes:   Definitions only
`ifndef SSP_PARAMS_SVH
`define SSP_PARAMS_SVH
`define SSP_OFS_CON1 8'h00
`define SSP_OFS_CON3 8'h04
`define SSP_OFS_MASK 8'h08
`define SSP_OFS_ADDR 8'h0c
`define SSP_OFS_BUF  8'h10
`define SSP_OFS_STAT 8'h14
`define SSP_RST_CON1 8'h00
`define SSP_RST_CON3 8'h00
`define SSP_RST_MASK 8'hff
`define SSP_RST_ADDR 8'h00
// Fields of port_control_one
`define SSP_C1_OV  6
`define SSP_C1_EN  5
`define SSP_C1_CKP 4
// Fields of port_status_reg
`define SSP_ST_BF  0
`define SSP_ST_BCL 1
`define SSP_ST_RW  2
// Mode encodings
`define SSP_M_SPIS_SS  4'h4
`define SSP_M_SPIS     4'h5
`define SSP_M_I2CS7    4'h6
`define SSP_M_I2CS10   4'h7
`define SSP_M_I2CM     4'h8
`define SSP_M_I2CFW    4'hb
`define SSP_M_I2CS7I   4'he
`define SSP_M_I2CS10I  4'hf
// Fixed upper pattern of a 10-bit high address byte
`define SSP_TEN_HI 5'b11110
// Timing
`define SSP_CLK_NS        25
`define SSP_HOLD_LONG_NS  300
`define SSP_HOLD_SHORT_NS 100
`define SSP_HOLD_LONG_CYC \
    ((`SSP_HOLD_LONG_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`define SSP_HOLD_SHORT_CYC \
    ((`SSP_HOLD_SHORT_NS + `SSP_CLK_NS - 1) / `SSP_CLK_NS)
`endif

// File: ssp_pkg.sv
// Purpose: Types shared by the serial port files
// Assumes: Nothing
// Notes:   Constants live in ssp_params.svh
package ssp_pkg;
    typedef struct packed {
        logic ack_phase_flag;
        logic stop_irq_enable;
        logic start_irq_enable;
        logic buffer_overwrite_enable;
        logic sda_hold_select;
        logic slave_collision_detect_enable;
        logic address_hold_enable;
        logic data_hold_enable;
    } ssp_ctrl3_s;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_RX   = 5'b00010,
        S_ACK  = 5'b00100,
        S_TX   = 5'b01000,
        S_TACK = 5'b10000
    } ssp_state_e;
endpackage : ssp_pkg

// File: ssp_slave_ctrl.sv
// Purpose: Serial port config, address match, hold and overflow logic
// Assumes: Pins synchronous to pclk; open-drain pins driven low by *_oe
// Notes:   APB slave, zero wait state; SPI slave receive only
//
// Added by the designer: register access over APB and the register offsets.
`include "ssp_params.svh"

module ssp_slave_ctrl
    import ssp_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        scl_in,
    output logic             scl_oe,
    input  wire logic        sda_in,
    output logic             sda_oe,
    input  wire logic        sck_in,
    input  wire logic        sdi_in,
    input  wire logic        ss_n_in,
    output logic             port_irq,
    output logic             collision_irq
);
    logic [7:0] con1, con3, msk, add, rx_buf, tx_buf, rx_sh;
    logic [7:0] tx_sh, next_con1, next_con3, rd_mux, spi_word;
    logic [6:0] spi_sh;
    logic [3:0] mode, bitcnt, hold_cnt;
    logic [2:0] spi_cnt, rise, fall;
    logic       bf, bcl, rw, is_addr, lo_pend, hi_ok, final_r;
    logic       ack_out, mack, m_scl, tick, next_bf, next_bcl;
    ssp_state_e st;
    ssp_ctrl3_s c3;

    // Bus decode
    wire setup  = psel & ~penable;
    wire acc    = psel & penable & pready;
    wire wr     = acc & pwrite;
    wire rd     = acc & ~pwrite;
    wire h_c1   = paddr == `SSP_OFS_CON1;
    wire h_c3   = paddr == `SSP_OFS_CON3;
    wire h_msk  = paddr == `SSP_OFS_MASK;
    wire h_add  = paddr == `SSP_OFS_ADDR;
    wire h_buf  = paddr == `SSP_OFS_BUF;
    wire h_st   = paddr == `SSP_OFS_STAT;
    wire mapped = h_c1 | h_c3 | h_msk | h_add | h_buf | h_st;
    wire w_c1   = wr & h_c1;
    wire w_c3   = wr & h_c3;
    wire buf_rd = rd & h_buf;

    // Mode decode
    assign mode = con1[3:0];
    assign c3   = ssp_ctrl3_s'(con3);
    wire en     = con1[`SSP_C1_EN];
    wire clock_release_bit    = con1[`SSP_C1_CKP];
    wire ov     = con1[`SSP_C1_OV];
    wire ten    = mode == `SSP_M_I2CS10 || mode == `SSP_M_I2CS10I;
    wire ssirq  = mode == `SSP_M_I2CS7I || mode == `SSP_M_I2CS10I;
    wire i2c_s  = en & (ten | ssirq | mode == `SSP_M_I2CS7);
    wire i2c_m  = en & (mode == `SSP_M_I2CM || mode == `SSP_M_I2CFW);
    wire i2c    = i2c_s | i2c_m;
    wire spi_s  = en & (mode == `SSP_M_SPIS_SS || mode == `SSP_M_SPIS);
    wire hold_en = c3.address_hold_enable | c3.data_hold_enable;

    ssp_edge #(
        .W    (3)
    ) u_edge (
        .pclk    (pclk),
        .presetn (presetn),
        .d       ({sck_in, sda_in, scl_in}),
        .rise    (rise),
        .fall    (fall)
    );

    ssp_baud_div #(
        .W    (8)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .en      (i2c_m),
        .div     (add),
        .tick    (tick)
    );

    // Bus conditions
    wire start_det = i2c & fall[1] & scl_in;
    wire stop_det  = i2c & rise[1] & scl_in;

    // Address compare
    wire m7 = ((rx_sh ^ add) & msk & 8'hfe) == 8'h00;
    wire lo = ((rx_sh ^ add) & msk) == 8'h00;
    wire hi = rx_sh[7:3] == `SSP_TEN_HI
            && ((rx_sh[2:1] ^ add[2:1]) & msk[2:1]) == 2'b00;
    wire addr_ok = !ten ? m7
                 : lo_pend ? lo : hi & (~rx_sh[0] | hi_ok);
    wire final_a = ~ten | lo_pend | rx_sh[0];

    // Byte end in slave receive
    wire byte_done = i2c_s && st == S_RX && fall[0] && bitcnt == 4'd8;
    wire accept    = ~bf & (c3.buffer_overwrite_enable | ~ov);
    wire ack_now   = accept & (~is_addr | addr_ok);
    wire i2c_load  = byte_done & ack_now;
    wire i2c_ov    = byte_done & bf & (~is_addr | addr_ok);
    wire ckp_clr   = byte_done & (is_addr ? addr_ok & c3.address_hold_enable
                                          : c3.data_hold_enable);
    wire coll      = i2c_s && st == S_TX && rise[0]
                     && tx_sh[7] && !sda_in;

    // SPI slave receive
    wire spi_act  = spi_s & (mode == `SSP_M_SPIS | ~ss_n_in);
    wire spi_edge = clock_release_bit ? fall[2] : rise[2];
    wire spi_byte = spi_act && spi_edge && spi_cnt == 3'd7;
    assign spi_word = {spi_sh, sdi_in};
    // Only slave modes reach the overwrite choice
    wire spi_load = spi_byte & (~bf | c3.buffer_overwrite_enable);
    wire set_ov   = i2c_ov | (spi_byte & bf);
    wire load     = i2c_load | spi_load;

    // Register next values; hardware set wins over software clear
    assign next_con1 = {1'b0,
        set_ov | (w_c1 ? pwdata[6] : ov),
        w_c1 ? pwdata[5] : en,
        ~ckp_clr & (w_c1 ? pwdata[4] : clock_release_bit),
        w_c1 ? pwdata[3:0] : mode};
    wire ack_nx = i2c_s & hold_en & (byte_done
                | (c3.ack_phase_flag & ~(st == S_ACK & rise[0])));
    assign next_con3 = {ack_nx, w_c3 ? pwdata[6:0] : con3[6:0]};
    assign next_bf   = load | (bf & ~buf_rd);
    assign next_bcl  = coll | (bcl & ~(wr & h_st & pwdata[`SSP_ST_BCL]));

    assign rd_mux = h_c1  ? con1
                  : h_c3  ? con3
                  : h_msk ? msk
                  : h_add ? add
                  : h_buf ? rx_buf
                  : h_st  ? {5'h00, rw, bcl, bf}
                  : 8'h00;

    // APB answer, one access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            if (setup) begin
                prdata <= {24'h00_0000, rd_mux};
            end
        end
    end

    // Registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            con1   <= `SSP_RST_CON1;
            con3   <= `SSP_RST_CON3;
            msk    <= `SSP_RST_MASK;
            add    <= `SSP_RST_ADDR;
            tx_buf <= 8'h00;
            bcl    <= 1'b0;
        end else begin
            con1 <= next_con1;
            con3 <= next_con3;
            bcl  <= next_bcl;
            if (wr & h_msk) begin
                msk <= pwdata[7:0];
            end
            if (wr & h_add) begin
                add <= pwdata[7:0];
            end
            if (wr & h_buf) begin
                tx_buf <= pwdata[7:0];
            end
        end
    end

    // Receive buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf <= 8'h00;
            bf     <= 1'b0;
        end else begin
            bf <= next_bf;
            if (load) begin
                rx_buf <= i2c_load ? rx_sh : spi_word;
            end
        end
    end

    // SPI shifter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            spi_sh  <= 7'h00;
            spi_cnt <= 3'd0;
        end else if (!spi_act) begin
            spi_cnt <= 3'd0;
        end else if (spi_edge) begin
            spi_sh  <= spi_word[6:0];
            spi_cnt <= spi_cnt + 3'd1;
        end
    end

    // I2C slave sequencer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st      <= S_IDLE;
            bitcnt  <= 4'd0;
            rx_sh   <= 8'h00;
            tx_sh   <= 8'h00;
            is_addr <= 1'b0;
            lo_pend <= 1'b0;
            hi_ok   <= 1'b0;
            final_r <= 1'b0;
            rw      <= 1'b0;
            ack_out <= 1'b0;
            mack    <= 1'b0;
        end else if (!i2c_s || coll) begin
            st      <= S_IDLE;
            ack_out <= 1'b0;
            hi_ok   <= 1'b0;
        end else if (start_det) begin
            st      <= S_RX;
            bitcnt  <= 4'd0;
            is_addr <= 1'b1;
            lo_pend <= 1'b0;
            ack_out <= 1'b0;
        end else if (stop_det) begin
            st    <= S_IDLE;
            hi_ok <= 1'b0;
        end else begin
            case (st)
                S_IDLE: begin
                    ack_out <= 1'b0;
                end
                S_RX: begin
                    if (rise[0]) begin
                        rx_sh  <= {rx_sh[6:0], sda_in};
                        bitcnt <= bitcnt + 4'd1;
                    end
                    if (byte_done) begin
                        st      <= S_ACK;
                        ack_out <= ack_now;
                        final_r <= final_a;
                        if (is_addr && !lo_pend) begin
                            rw    <= rx_sh[0];
                            hi_ok <= hi_ok | (ten & hi & ack_now);
                        end
                    end
                end
                S_ACK: begin
                    if (fall[0]) begin
                        ack_out <= 1'b0;
                        bitcnt  <= 4'd0;
                        tx_sh   <= tx_buf;
                        if (!ack_out) begin
                            st <= S_IDLE;
                        end else if (is_addr && !final_r) begin
                            st      <= S_RX;
                            lo_pend <= 1'b1;
                        end else if (is_addr && rw) begin
                            st <= S_TX;
                        end else begin
                            st      <= S_RX;
                            is_addr <= 1'b0;
                        end
                    end
                end
                S_TX: begin
                    if (fall[0]) begin
                        tx_sh  <= {tx_sh[6:0], 1'b1};
                        bitcnt <= bitcnt + 4'd1;
                        if (bitcnt == 4'd7) begin
                            st <= S_TACK;
                        end
                    end
                end
                S_TACK: begin
                    if (rise[0]) begin
                        mack <= ~sda_in;
                    end
                    if (fall[0]) begin
                        st     <= mack ? S_TX : S_IDLE;
                        tx_sh  <= tx_buf;
                        bitcnt <= 4'd0;
                    end
                end
                default: begin
                    st <= S_IDLE;
                end
            endcase
        end
    end

    // Pin drive with SDA hold after each SCL fall
    wire want_sda = (st == S_ACK && ack_out) || (st == S_TX && !tx_sh[7]);
    wire want_scl = (i2c_s && !clock_release_bit && st != S_IDLE)
                  || (i2c_m && !m_scl);
    wire [3:0] hold_ld = c3.sda_hold_select
                       ? 4'(`SSP_HOLD_LONG_CYC) : 4'(`SSP_HOLD_SHORT_CYC);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hold_cnt <= 4'd0;
            sda_oe   <= 1'b0;
            scl_oe   <= 1'b0;
            m_scl    <= 1'b1;
        end else begin
            scl_oe <= want_scl;
            if (i2c && fall[0]) begin
                hold_cnt <= hold_ld;
            end else if (hold_cnt != 4'd0) begin
                hold_cnt <= hold_cnt - 4'd1;
            end else begin
                sda_oe <= want_sda;
            end
            m_scl <= !i2c_m ? 1'b1 : (tick ? ~m_scl : m_scl);
        end
    end

    // Interrupt pulses
    wire start_ev = start_det & (c3.start_irq_enable | ssirq);
    wire stop_ev  = stop_det & (c3.stop_irq_enable | ssirq);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_irq      <= 1'b0;
            collision_irq <= 1'b0;
        end else begin
            port_irq      <= start_ev | stop_ev | i2c_load | spi_byte;
            collision_irq <= coll & c3.slave_collision_detect_enable;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ack_clear_a: assert property (c3.ack_phase_flag && st == S_ACK && rise[0]
        |=> !c3.ack_phase_flag) else $error("ack flag not cleared");
    ack_gate_a: assert property ($rose(c3.ack_phase_flag)
        |-> $past(hold_en) && $past(byte_done)) else $error("ack flag bad set");
    stop_irq_a: assert property (stop_det && c3.stop_irq_enable
        |=> port_irq) else $error("stop irq missing");
    start_irq_a: assert property (start_det && ssirq
        |=> port_irq) else $error("start irq missing");
    spi_keep_a: assert property (spi_byte && bf
        && !c3.buffer_overwrite_enable
        |=> ov && $stable(rx_buf)) else $error("overflow handling");
    spi_ovw_a: assert property (spi_byte && bf
        && c3.buffer_overwrite_enable
        |=> ov && rx_buf == $past(spi_word)) else $error("overwrite");
    hold_time_a: assert property (hold_cnt != 4'd0
        |=> $stable(sda_oe)) else $error("sda changed in hold");
    coll_idle_a: assert property (coll
        |=> bcl && st == S_IDLE ##1 !sda_oe [*2]) else $error("collision");
    addr_hold_a: assert property (byte_done && is_addr && addr_ok
        && c3.address_hold_enable |=> !clock_release_bit ##1 scl_oe)
        else $error("address hold");
    data_hold_a: assert property (byte_done && !is_addr
        && c3.data_hold_enable |=> !clock_release_bit) else $error("data hold");
endmodule // ssp_slave_ctrl

// File: test_serial_port_slave_addr_hold_ctrl.sv
// Purpose: Self-checking bench for the slave port control block
// Assumes: Zero wait APB, open-drain wires pulled up
// Notes:   Read data is compared from a queue of expected values
`include "ssp_params.svh"

module test_serial_port_slave_addr_hold_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0] C1 = `SSP_OFS_CON1;
    localparam logic [7:0] C3 = `SSP_OFS_CON3;
    localparam logic [7:0] MK = `SSP_OFS_MASK;
    localparam logic [7:0] AD = `SSP_OFS_ADDR;
    localparam logic [7:0] RB = `SSP_OFS_BUF;
    localparam logic [7:0] ST = `SSP_OFS_STAT;

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        scl_oe;
    logic        sda_oe;
    logic        sck_in;
    logic        sdi_in;
    logic        port_irq;
    logic        collision_irq;
    logic        m_scl;
    logic        m_sda;
    logic        m_to;
    logic        ack;
    logic [2:0]  q;
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic [8:0]  expq[$];
    int          n_fail, compares, seed, irqs, n0;
    int          since, hold_seen, gap, rise_at, cyc, colls;
    wire         scl = ~(scl_oe | m_scl);
    wire         sda = ~(sda_oe | m_sda);

    ssp_slave_ctrl uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .scl_in(scl), .scl_oe(scl_oe),
        .sda_in(sda), .sda_oe(sda_oe), .sck_in(sck_in), .sdi_in(sdi_in),
        .ss_n_in(1'b1), .port_irq(port_irq),
        .collision_irq(collision_irq)
    );
    spsahc_i2c_mst mst (
        .pclk(pclk), .scl(scl), .sda(sda), .scl_low(m_scl),
        .sda_low(m_sda), .timed_out(m_to)
    );

    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end

    task automatic check(input logic [8:0] got, input logic [8:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic test_done(input bit hang);
        if (hang) n_fail++;
        $display("Counts: %0d compares, %0d failures", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    // Read results compared as they appear; wire timing and pulse counts recorded
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            if (expq.size() == 0) check(9'h1ff, 9'h000);
            else check({pslverr, prdata[7:0]}, expq.pop_front());
        end
        if (port_irq === 1'b1) irqs++;
        if (collision_irq === 1'b1) colls++;
        if (q[0] && !scl) since = 0;
        else since++;
        if (sda_oe === 1'b1 && !q[1]) hold_seen = since;
        if (scl_oe === 1'b1 && !q[2]) gap = cyc - rise_at;
        if (scl_oe === 1'b1 && !q[2]) rise_at = cyc;
        q = {scl_oe === 1'b1, sda_oe === 1'b1, scl};
        cyc++;
    end

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [7:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) test_done(1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [8:0] e);
        expq.push_back(e);
        apb(1'b0, a, 8'h00);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic addr_try(input logic [7:0] a, input logic e,
                            input logic [7:0] m);
        wr(MK, m);
        mst.start();
        mst.send(a, ack);
        check({8'h0, ack}, {8'h0, e});
        mst.stop();
        if (e) rd(RB, {1'b0, a});
    endtask

    // Byte that the slave holds: flag and release bit seen mid-stretch
    task automatic hold_byte(input logic [7:0] d, input logic [7:0] h);
        int n;
        fork
            mst.send(d, ack);
            begin
                n = 0;
                while (scl_oe !== 1'b1 && n < 900) begin
                    @(posedge pclk);
                    n++;
                end
                if (scl_oe !== 1'b1) test_done(1);
                rd(C3, {2'b01, h[6:0]});
                rd(C1, 9'h026);
                wr(C1, 8'h36);
            end
        join
        check({8'h0, ack}, 9'h001);
        rd(C3, {1'b0, h});
        rd(RB, {1'b0, d});
    endtask

    task automatic spi_byte(input logic [7:0] d);
        for (int i = 7; i >= 0; i--) begin
            sdi_in <= d[i];
            repeat (4) @(posedge pclk);
            sck_in <= 1'b1;
            repeat (4) @(posedge pclk);
            sck_in <= 1'b0;
        end
        sdi_in <= ~d[0];
        repeat (4) @(posedge pclk);
    endtask

    initial begin
        {psel, penable, pwrite, presetn, sck_in, sdi_in} = 6'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        {n_fail, compares, irqs, since, gap, rise_at, cyc} = '0;
        hold_seen = 0;
        colls = 0;
        q = 3'h0;
        seed = 65784;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(C1, 9'h000);
        rd(C3, 9'h000);
        rd(MK, 9'h0ff);
        rd(AD, 9'h000);
        rd(8'h18, 9'h100);
        wr(C3, 8'hff);
        rd(C3, 9'h07f);
        $display("Test registers done");
        wr(C3, 8'h08);
        wr(AD, 8'h85);
        wr(C1, 8'h36);
        addr_try(8'h84, 1'b1, 8'hff);
        addr_try(8'h86, 1'b0, 8'hff);
        addr_try(8'h86, 1'b1, 8'hfd);
        check({8'h0, hold_seen >= 12}, 9'h001);
        $display("Test address match done");
        d1 = 8'($random(seed));
        d2 = 8'($random(seed));
        wr(MK, 8'hff);
        mst.start();
        mst.send(8'h84, ack);
        rd(RB, 9'h084);
        mst.send(d1, ack);
        rd(ST, 9'h001);
        mst.send(d2, ack);
        check({8'h0, ack}, 9'h000);
        mst.stop();
        rd(C1, 9'h076);
        rd(RB, {1'b0, d1});
        for (int b = 0; b < 2; b++) begin
            wr(C3, {3'h0, b[0], 4'h0});
            mst.start();
            mst.send(8'h84, ack);
            mst.stop();
            rd(ST, {8'h0, b[0]});
        end
        check({8'h0, ack}, 9'h001);
        rd(RB, 9'h084);
        wr(C1, 8'h36);
        $display("Test overflow done");
        wr(C3, 8'h02);
        mst.start();
        hold_byte(8'h84, 8'h02);
        wr(C3, 8'h01);
        mst.start();
        mst.send(8'h84, ack);
        rd(RB, 9'h084);
        hold_byte(d2, 8'h01);
        mst.stop();
        $display("Test clock hold done");
        // Slave sends ones while the far side pulls SDA low
        wr(C3, 8'h04);
        wr(RB, 8'hff);
        n0 = colls;
        mst.start();
        mst.send(8'h85, ack);
        check({8'h0, ack}, 9'h001);
        mst.send(8'h00, ack);
        check({8'h0, ack}, 9'h000);
        mst.stop();
        check(9'(colls - n0), 9'd1);
        rd(ST, 9'h007);
        wr(ST, 8'h02);
        rd(ST, 9'h005);
        rd(RB, 9'h085);
        $display("Test collision done");
        for (int i = 0; i < 5; i++) begin
            wr(C1, (i == 4) ? 8'h3e : 8'h36);
            wr(C3, (i == 4) ? 8'h00 : {1'b0, 2'(i), 5'h0});
            n0 = irqs;
            mst.start();
            mst.start();
            mst.stop();
            repeat (4) @(posedge pclk);
            check(9'(irqs - n0),
                  (i == 4) ? 9'd3 : 9'(2 * i[0] + i[1]));
        end
        $display("Test start stop done");
        for (int b = 0; b < 2; b++) begin
            wr(C1, 8'h25);
            wr(C3, {3'h0, b[0], 4'h0});
            spi_byte(d1);
            spi_byte(d2);
            rd(C1, 9'h065);
            rd(RB, {1'b0, b[0] ? d2 : d1});
        end
        $display("Test SPI overwrite done");
        wr(AD, 8'h03);
        wr(C1, 8'h28);
        repeat (80) @(posedge pclk);
        check(9'(gap), 9'd16);
        $display("Test divider done");
        check({8'h0, m_to}, 9'h000);
        test_done(0);
    end
endmodule // test_serial_port_slave_addr_hold_ctrl
